// File: prrc_ctrl.sv
// Host-side readout controller for the pixel array, AHB-Lite register slave.
`timescale 1ns/1ns
module prrc_ctrl (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, active low
  input wire logic clk_en, // Freeze all state when low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response
  output logic read_row_clock, // Read row pointer clock
  output logic reset_row_clock, // Reset row pointer clock
  output logic read_row_sync, // Read row sync
  output logic reset_row_sync, // Reset row sync
  output logic row_start_load, // Row start load strobe
  output logic column_start_load, // Column start load strobe
  output logic [8:0] start_addr, // Shared start address bus
  output logic column_clock, // Column clock
  output logic column_sync, // Column pointer reload
  output logic pixel_reset, // Pixel reset strobe
  output logic sample_strobe, // Signal sample strobe
  output logic calibrate, // Calibration input
  output logic gain_select_low, // Gain pin 0
  output logic gain_select_high, // Gain pin 1
  input wire logic [9:0] adc_data // Sensor pixel word
);
  logic [31:0] ctrl_reg, row_reg, col_reg, pix_reg;
  logic [9:0] adc_s1_reg, adc_s2_reg;
  logic wr_pend_reg;
  logic [11:0] wa_reg;
  logic [31:0] rdata_next;
  prrc_pkg::prrc_st_e st_reg;
  logic [15:0] cnt_reg;
  logic [8:0] line_reg, pcnt_reg, sh_reg;
  logic first_frame_reg, pix_new_reg, first_line_reg;
  logic [8:0] row_first, row_count, col_first, col_count, shutter;
  assign row_first = row_reg[8:0];
  assign row_count = row_reg[prrc_pkg::FLD_HI+8:prrc_pkg::FLD_HI];
  assign col_first = col_reg[8:0];
  assign col_count = col_reg[prrc_pkg::FLD_HI+9:prrc_pkg::FLD_HI+1];
  // Delay lines = shutter + 1, so shutter lead 0 means a one-line exposure
  assign shutter = ctrl_reg[prrc_pkg::FLD_HI+8:prrc_pkg::FLD_HI];

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      adc_s1_reg <= 10'h000;
      adc_s2_reg <= 10'h000;
    end
    else if (clk_en)
    begin
      adc_s1_reg <= adc_data;
      adc_s2_reg <= adc_s1_reg;
    end

  always_comb
  begin
    case (haddr[11:0])
      prrc_pkg::OFS_CTRL: rdata_next = ctrl_reg;
      prrc_pkg::OFS_ROW: rdata_next = row_reg;
      prrc_pkg::OFS_COL: rdata_next = col_reg;
      prrc_pkg::OFS_STAT: rdata_next = {23'h000000, line_reg};
      prrc_pkg::OFS_PIX: rdata_next = pix_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
    // Forward a write still in its data phase to a read of the same word
    if (wr_pend_reg && wa_reg == haddr[11:0] && (wa_reg ==
        prrc_pkg::OFS_CTRL || wa_reg == prrc_pkg::OFS_ROW ||
        wa_reg == prrc_pkg::OFS_COL))
      rdata_next = hwdata;
  end

  // Zero-wait slave: read data is registered at the address phase, so it
  // already stands through the whole data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wa_reg <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1])
        wa_reg <= haddr[11:0];
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata <= rdata_next;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ctrl_reg <= prrc_pkg::CTRL_RST;
      row_reg <= prrc_pkg::ROW_RST;
      col_reg <= prrc_pkg::COL_RST;
    end
    else if (clk_en && wr_pend_reg)
      case (wa_reg)
        prrc_pkg::OFS_CTRL: ctrl_reg <= hwdata;
        prrc_pkg::OFS_ROW: row_reg <= hwdata;
        prrc_pkg::OFS_COL: col_reg <= hwdata;
        default: ;
      endcase

  // Gain pins are registered straight from software; four presets
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      gain_select_low <= 1'b0;
      gain_select_high <= 1'b0;
    end
    else if (clk_en)
    begin
      gain_select_low <= ctrl_reg[prrc_pkg::CTRL_GAIN];
      gain_select_high <= ctrl_reg[prrc_pkg::CTRL_GAIN+1];
    end

  // Line sequencer; one counter times every strobe, so each minimum delay
  // is met by construction rather than by software pacing
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      st_reg <= prrc_pkg::ST_IDLE;
      cnt_reg <= 16'h0000;
      line_reg <= 9'h000;
      pcnt_reg <= 9'h000;
      first_line_reg <= 1'b1;
    end
    else if (clk_en)
      case (st_reg)
        prrc_pkg::ST_IDLE:
          if (ctrl_reg[prrc_pkg::CTRL_RUN])
          begin
            st_reg <= prrc_pkg::ST_LDROW;
            cnt_reg <= 16'h0000;
          end
        prrc_pkg::ST_LDROW:
          if (cnt_reg == prrc_pkg::LOAD_W_CYC * 16'd2)
          begin
            st_reg <= prrc_pkg::ST_BLANK;
            cnt_reg <= 16'h0000;
          end
          else
            cnt_reg <= cnt_reg + 16'h0001;
        prrc_pkg::ST_BLANK:
          if (cnt_reg == prrc_pkg::BLANK_CYC)
          begin
            st_reg <= prrc_pkg::ST_LDCOL;
            cnt_reg <= 16'h0000;
          end
          else
            cnt_reg <= cnt_reg + 16'h0001;
        prrc_pkg::ST_LDCOL:
          if (cnt_reg == prrc_pkg::LOAD_W_CYC * 16'd2)
          begin
            st_reg <= prrc_pkg::ST_PIX;
            cnt_reg <= 16'h0000;
            pcnt_reg <= 9'h000;
          end
          else
            cnt_reg <= cnt_reg + 16'h0001;
        prrc_pkg::ST_PIX:
          if (cnt_reg == prrc_pkg::PIX_HALF_CYC * 16'd2 - 16'h0001)
          begin
            cnt_reg <= 16'h0000;
            if (pcnt_reg == col_count)
              st_reg <= prrc_pkg::ST_NEXT;
            pcnt_reg <= pcnt_reg + 9'h001;
          end
          else
            cnt_reg <= cnt_reg + 16'h0001;
        prrc_pkg::ST_NEXT:
        begin
          first_line_reg <= (line_reg == row_count);
          line_reg <= (line_reg == row_count) ? 9'h000 : line_reg + 9'h001;
          st_reg <= ctrl_reg[prrc_pkg::CTRL_RUN] ?
            prrc_pkg::ST_BLANK : prrc_pkg::ST_IDLE;
          cnt_reg <= 16'h0000;
        end
        default: st_reg <= prrc_pkg::ST_IDLE;
      endcase

  // Shutter row index: reset pointer leads by the programmed shutter value, wrapping at the row count
  always_comb
    sh_reg = (line_reg + shutter >= row_count + 9'h001) ?
      9'(line_reg + shutter - row_count - 9'h001) : 9'(line_reg + shutter);

  // Row strobes; syncs only on first line of frame (shutter: on its lead line)
  // Sample strobe lies ahead of both pixel resets, so the signal level is
  // taken before the row is drained
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      read_row_sync <= 1'b0;
      reset_row_sync <= 1'b0;
      read_row_clock <= 1'b0;
      reset_row_clock <= 1'b0;
      calibrate <= 1'b0;
      pixel_reset <= 1'b0;
      sample_strobe <= 1'b0;
    end
    else if (clk_en)
    begin
      read_row_sync <= st_reg == prrc_pkg::ST_BLANK && line_reg == 9'h000 &&
        cnt_reg < prrc_pkg::SYNC_W_CYC;
      reset_row_sync <= st_reg == prrc_pkg::ST_BLANK && sh_reg == 9'h000 &&
        cnt_reg < prrc_pkg::SYNC_W_CYC;
      read_row_clock <= st_reg == prrc_pkg::ST_BLANK && line_reg != 9'h000 &&
        cnt_reg < prrc_pkg::SYNC_W_CYC;
      reset_row_clock <= st_reg == prrc_pkg::ST_BLANK && sh_reg != 9'h000 &&
        cnt_reg < prrc_pkg::SYNC_W_CYC;
      calibrate <= st_reg == prrc_pkg::ST_BLANK && line_reg == 9'h000 &&
        cnt_reg >= prrc_pkg::CAL_AT_CYC &&
        cnt_reg < prrc_pkg::CAL_AT_CYC + prrc_pkg::CAL_W_CYC;
      sample_strobe <= st_reg == prrc_pkg::ST_BLANK &&
        cnt_reg >= prrc_pkg::IDLE_CYC - prrc_pkg::RST_W_CYC * 16'd4 &&
        cnt_reg < prrc_pkg::IDLE_CYC;
      pixel_reset <= st_reg == prrc_pkg::ST_BLANK &&
        ((cnt_reg >= prrc_pkg::RST1_AT_CYC &&
          cnt_reg < prrc_pkg::RST1_AT_CYC + prrc_pkg::RST_W_CYC) ||
         (cnt_reg >= prrc_pkg::RST2_AT_CYC &&
          cnt_reg < prrc_pkg::RST2_AT_CYC + prrc_pkg::RST_W_CYC));
    end

  // Start bus, load strobes, column clock and pixel capture
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      start_addr <= 9'h000;
      row_start_load <= 1'b0;
      column_start_load <= 1'b0;
      column_sync <= 1'b0;
      column_clock <= 1'b0;
      pix_reg <= 32'h0000_0000;
      pix_new_reg <= 1'b0;
      first_frame_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      start_addr <= st_reg == prrc_pkg::ST_LDROW ? row_first : col_first;
      // Strobe sits mid-window so the address has setup and hold margin
      row_start_load <= st_reg == prrc_pkg::ST_LDROW &&
        cnt_reg >= prrc_pkg::LOAD_W_CYC / 16'd2 &&
        cnt_reg < prrc_pkg::LOAD_W_CYC * 16'd3 / 16'd2;
      column_start_load <= st_reg == prrc_pkg::ST_LDCOL &&
        cnt_reg >= prrc_pkg::LOAD_W_CYC / 16'd2 &&
        cnt_reg < prrc_pkg::LOAD_W_CYC * 16'd3 / 16'd2;
      column_sync <= st_reg == prrc_pkg::ST_LDCOL &&
        cnt_reg == prrc_pkg::LOAD_W_CYC * 16'd2;
      column_clock <= st_reg == prrc_pkg::ST_PIX &&
        cnt_reg < prrc_pkg::PIX_HALF_CYC;
      pix_new_reg <= st_reg == prrc_pkg::ST_PIX &&
        cnt_reg == prrc_pkg::PIX_HALF_CYC * 16'd2 - 16'h0001;
      if (pix_new_reg)
        pix_reg <= {first_frame_reg, 21'h000000, adc_s2_reg};
      if (st_reg == prrc_pkg::ST_NEXT && line_reg == row_count)
        first_frame_reg <= 1'b0;
    end

  sync_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(read_row_sync) |-> read_row_sync [*8])
    else $error("read sync too short");
  cal_after_sync_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(calibrate) |-> !read_row_sync)
    else $error("calibration overlaps sync");
  gain_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> gain_select_low == $past(ctrl_reg[prrc_pkg::CTRL_GAIN]))
    else $error("gain pin mismatch");
  clk_sync_excl_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(read_row_clock && read_row_sync))
    else $error("row clock with sync");
  no_pix_blank_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_strobe |-> !column_clock)
    else $error("pixel read in row init");
  rst_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(pixel_reset) |-> pixel_reset [*8])
    else $error("reset pulse too short");
  load_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(row_start_load && column_start_load))
    else $error("loads overlap");
  colsync_a: assert property (@(posedge hclk) disable iff (!hresetn)
    column_sync |-> !column_clock)
    else $error("column reload during clock");
  smp_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pixel_reset |-> !sample_strobe)
    else $error("pixel reset during sample");
  cv_frame: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(read_row_sync));
  cv_cal: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(calibrate));
  cv_pix: cover property (@(posedge hclk) disable iff (!hresetn)
    pix_new_reg);
  cv_shutter: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(reset_row_sync));
endmodule : prrc_ctrl

// File: prrc_pkg.sv
// Constants for the pixel array row and column readout controller.
// Function
// - Vertical window: preset a start row, clock only the rows needed.
// - Integration time is row count times blanking plus pixel time per row.
// - Output gain is one of four values set by two gain pins.
// - Read continuously without setup; flag the first frame as invalid.
// - Pulse both row syncs on a frame's first line only. The code pulses reset sync on the line whose shutter row is 0.
// - Each line gives two pixel reset pulses: read row and shutter row.
// - Each line reloads the column start, then reads and clocks every pixel.
// - Advance both row pointers each line; wrap with sync at window end.
// - Delay lines equal reset row minus read row plus one.
// - Clock both row pointers alike; reset sync leads by integration rows.
// - Pulse calibration on each frame's first row, 2 us after read sync.
// - Wait 1.4 us row idle and avoid reads during row initialisation.
// - Load the row start value before the sync pulse that uses it.
// - Calibration high selects black reference; assert it once per frame.
// - Load start values on the shared address bus with a load strobe.
package prrc_pkg;
  localparam int CLK_NS = 8;
  localparam int BLANK_NS = 3200;
  localparam int CAL_DELAY_NS = 2000;
  localparam int CAL_WIDTH_NS = 100;
  localparam int IDLE_NS = 1400;
  localparam int SYNC_W_NS = 400;
  localparam int LOAD_W_NS = 24;
  localparam int PIX_NS = 128;
  localparam logic [15:0] BLANK_CYC = 16'((BLANK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CAL_AT_CYC = 16'(CAL_DELAY_NS / CLK_NS);
  localparam logic [15:0] CAL_W_CYC =
    16'((CAL_WIDTH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] IDLE_CYC = 16'((IDLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] SYNC_W_CYC = 16'(SYNC_W_NS / CLK_NS);
  localparam logic [15:0] LOAD_W_CYC = 16'((LOAD_W_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] PIX_HALF_CYC = 16'(PIX_NS / CLK_NS / 2);
  // Both resets sit after the sample strobe and inside the blanking count
  localparam logic [15:0] RST1_AT_CYC = 16'd200;
  localparam logic [15:0] RST2_AT_CYC = 16'd300;
  localparam logic [15:0] RST_W_CYC = 16'd13;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ROW = 12'h004;
  localparam logic [11:0] OFS_COL = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00c;
  localparam logic [11:0] OFS_PIX = 12'h010;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ROW_RST = 32'h01ff_0000;
  localparam logic [31:0] COL_RST = 32'h0200_0000;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_GAIN = 1;
  localparam int FLD_HI = 16;
  typedef enum {ST_IDLE, ST_LDROW, ST_LDCOL, ST_BLANK, ST_PIX,
    ST_NEXT} prrc_st_e;
endpackage : prrc_pkg

// File: prrc_sensor_model.sv
// Behavioural model of the sensor's row, column and converter pins.
`timescale 1ns/1ns
module prrc_sensor_model #(
  parameter int ROWS = 512, // Rows in the array
  parameter logic [9:0] BLACK = 10'h040 // Black reference code
) (
  input wire logic read_row_clock, // Read pointer clock
  input wire logic reset_row_clock, // Reset pointer clock
  input wire logic read_row_sync, // Read pointer preset
  input wire logic reset_row_sync, // Reset pointer preset
  input wire logic row_start_load, // Row start strobe
  input wire logic column_start_load, // Column start strobe
  input wire logic [8:0] start_addr, // Start address bus
  input wire logic column_clock, // Column clock
  input wire logic column_sync, // Column pointer preset
  input wire logic pixel_reset, // Pixel reset strobe
  input wire logic sample_strobe, // Signal sample strobe
  input wire logic calibrate, // Black reference select
  input wire logic gain_select_low, // Gain pin 0
  input wire logic gain_select_high, // Gain pin 1
  output logic [9:0] adc_data // Converted pixel word
);
  logic [8:0] row_start_reg = 9'h000;
  logic [8:0] col_start_reg = 9'h000;
  logic [ROWS-1:0] fresh_reg = '0;
  logic sat_reg = 1'b1;
  int read_idx = 0;
  int reset_idx = 0;
  int col_idx = 0;
  initial adc_data = 10'h000;
  always @(negedge row_start_load) row_start_reg = start_addr;
  always @(negedge column_start_load) col_start_reg = start_addr;
  // Pointers kept as indices, so each of the two pointers selects exactly one row
  always @(negedge read_row_sync) read_idx = row_start_reg;
  always @(negedge read_row_clock) read_idx = (read_idx + 1) % ROWS;
  always @(negedge reset_row_sync) reset_idx = row_start_reg;
  always @(negedge reset_row_clock) reset_idx = (reset_idx + 1) % ROWS;
  // Sampling drains the row; a row never reset reads saturated
  always @(posedge sample_strobe)
  begin
    sat_reg = !fresh_reg[read_idx];
    fresh_reg[read_idx] = 1'b0;
  end
  always @(posedge pixel_reset)
  begin
    fresh_reg[read_idx] = 1'b1;
    fresh_reg[reset_idx] = 1'b1;
  end
  always @(posedge column_sync) col_idx = col_start_reg;
  always @(negedge column_clock) col_idx = col_idx + 1;
  // Output changes only on a rising column clock or a rising calibrate
  always @(posedge column_clock or posedge calibrate)
  begin
    if (calibrate)
      adc_data = BLACK;
    else if (sat_reg)
      adc_data = 10'h3ff;
    else
      adc_data = {2'b00, read_idx[3:0], col_idx[3:0]}
        << {gain_select_high, gain_select_low};
  end
endmodule : prrc_sensor_model

// File: tb.sv
// Self-checking bench: controller, sensor model and AHB-Lite master.
`timescale 1ns/1ns
module tb;
  logic hclk, hresetn, hwrite, hreadyout, hresp, rd_dp, seen_line;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, g;
  logic rrc, xrc, rrs, xrs, rsl, csl, cclk, csync, prst, samp, cal, g0, g1;
  logic p_rrs, p_xrs, p_rrc, p_cs, p_cc, p_pr, p_cal, first_px;
  logic [8:0] start_addr;
  logic [9:0] adc_data;
  logic [31:0] exp_q[$], msk_q[$];
  int fails, n_compared, frames, line, clks, cols, rsts, cals, xsyncs;
  int since_sync, since_row, s_row, n_lines, n_pix, lead, c0, i;

  prrc_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .read_row_clock(rrc),
    .reset_row_clock(xrc), .read_row_sync(rrs), .reset_row_sync(xrs),
    .row_start_load(rsl), .column_start_load(csl),
    .start_addr(start_addr), .column_clock(cclk), .column_sync(csync),
    .pixel_reset(prst), .sample_strobe(samp), .calibrate(cal),
    .gain_select_low(g0), .gain_select_high(g1), .adc_data(adc_data));
  prrc_sensor_model u_sensor (
    .read_row_clock(rrc), .reset_row_clock(xrc), .read_row_sync(rrs),
    .reset_row_sync(xrs), .row_start_load(rsl), .column_start_load(csl),
    .start_addr(start_addr), .column_clock(cclk), .column_sync(csync),
    .pixel_reset(prst), .sample_strobe(samp), .calibrate(cal),
    .gain_select_low(g0), .gain_select_high(g1), .adc_data(adc_data));

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        fails++;
        tally_and_finish();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  task automatic ahb(input logic w, input logic [11:0] ofs,
                     input logic [31:0] d, input logic [31:0] m);
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    haddr <= {20'h0, ofs};
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask : ahb

  task automatic wait_until(input int f, input int l);
    int n;
    for (n = 0; n < 40000 && !(frames >= f && line >= l); n++)
      @(posedge hclk);
    if (!(frames >= f && line >= l))
    begin
      fails++;
      tally_and_finish();
    end
  endtask : wait_until

  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk)
  begin
    if (rd_dp && hreadyout === 1'b1)
      check(hrdata & msk_q.pop_front(), exp_q.pop_front());
    if (hreadyout === 1'b1)
      rd_dp <= htrans[1] && !hwrite;
  end

  always @(posedge hclk)
  begin
    since_sync++;
    since_row++;
    if ((rrc && !p_rrc) || (rrs && !p_rrs))
      since_row = 0;
    clks += int'(rrc && !p_rrc);
    xsyncs += int'(xrs && !p_xrs);
    rsts += int'(prst && !p_pr);
    if (rrs && !p_rrs)
    begin
      if (frames > 0)
      begin
        check(clks, n_lines - 1);
        check(cals, 1);
        check(xsyncs, 1);
        check(line, n_lines);
      end
      frames++;
      line = 0;
      clks = 0;
      cals = 0;
      xsyncs = 0;
      since_sync = 0;
    end
    if (cal && !p_cal)
    begin
      cals++;
      check(32'(since_sync >= prrc_pkg::CAL_AT_CYC && since_sync <=
        prrc_pkg::CAL_AT_CYC + prrc_pkg::SYNC_W_CYC), 1);
    end
    if (!cclk && p_cc)
    begin
      if (first_px)
        check(32'(since_row >= prrc_pkg::IDLE_CYC), 1);
      first_px = 1'b0;
      cols++;
    end
    if (csync && !p_cs)
    begin
      if (seen_line)
        check(cols, n_pix);
      check(rsts, 2);
      check(u_sensor.read_idx, s_row + line);
      if (frames > 1)
        check((u_sensor.reset_idx - u_sensor.read_idx + n_lines) % n_lines,
          lead);
      seen_line = 1'b1;
      first_px = 1'b1;
      cols = 0;
      rsts = 0;
      line++;
    end
    {p_rrs, p_xrs, p_rrc, p_cs, p_cc, p_pr, p_cal} =
      {rrs, xrs, rrc, csync, cclk, prst, cal};
  end

  initial
  begin
    {hresetn, hwrite, rd_dp, seen_line, first_px} = 5'h00;
    {p_rrs, p_xrs, p_rrc, p_cs, p_cc, p_pr, p_cal} = 7'h00;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    {fails, n_compared, frames, line, clks, cols, rsts, cals} = '0;
    {xsyncs, since_sync, since_row} = '0;
    n_lines = 4;
    void'($urandom(72912));
    s_row = 16 + $urandom % 200;
    n_pix = 6 + $urandom % 4;
    lead = 1 + $urandom % 2;
    c0 = $urandom % 300;
    g = $urandom % 4;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, prrc_pkg::OFS_CTRL, prrc_pkg::CTRL_RST, '1);
    ahb(0, prrc_pkg::OFS_ROW, prrc_pkg::ROW_RST, '1);
    ahb(0, prrc_pkg::OFS_COL, prrc_pkg::COL_RST, '1);
    ahb(1, 12'h020, 32'hffff_ffff, '1);
    ahb(0, 12'h020, 32'h0000_0000, '1);
    for (i = 0; i < 4; i++)
    begin
      g = (g + 1) % 4;
      ahb(1, prrc_pkg::OFS_CTRL, g << 1, '1);
      repeat (3) @(posedge hclk);
      check(32'({g1, g0}), g);
      ahb(0, prrc_pkg::OFS_CTRL, g << 1, '1);
    end
    ahb(1, prrc_pkg::OFS_ROW, {7'h0, 9'(n_lines - 1), 7'h0, 9'(s_row)}, '1);
    ahb(1, prrc_pkg::OFS_COL, {6'h0, 9'(n_pix - 1), 8'h0, 9'(c0)}, '1);
    ahb(1, prrc_pkg::OFS_CTRL, {7'h0, 9'(lead), 13'h0, g[1:0], 1'b1}, '1);
    wait_until(1, 2);
    ahb(0, prrc_pkg::OFS_PIX, 32'h8000_0000, 32'h8000_0000);
    wait_until(4, 1);
    ahb(0, prrc_pkg::OFS_PIX, 32'h0000_0000, 32'h8000_0000);
    check(u_sensor.row_start_reg, s_row);
    check(u_sensor.col_start_reg, c0);
    ahb(1, prrc_pkg::OFS_CTRL, 32'h0000_0000, '1);
    repeat (5) @(posedge hclk);
    tally_and_finish();
  end
endmodule : tb
